/* File: verilog/ulml_pkg.sv */
package ulml_pkg;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_CONTROL   = 8'h00;
  localparam logic [7:0]  OFS_MODE      = 8'h04;
  localparam logic [7:0]  OFS_IRQ_EN    = 8'h08;
  localparam logic [7:0]  OFS_IRQ_DIS   = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h10;
  localparam logic [7:0]  OFS_STATUS    = 8'h14;
  localparam logic [7:0]  OFS_RX_HOLD   = 8'h18;
  localparam logic [7:0]  OFS_TX_HOLD   = 8'h1C;
  localparam logic [7:0]  OFS_BAUD      = 8'h20;
  localparam logic [7:0]  OFS_RX_TMO    = 8'h24;
  localparam logic [7:0]  OFS_TIMEGUARD = 8'h28;
  localparam logic [7:0]  OFS_CLK_RATIO = 8'h40;
  localparam logic [7:0]  OFS_ERR_CNT   = 8'h44;
  localparam logic [7:0]  OFS_IR_FILTER = 8'h4C;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
  localparam logic [31:0] RST_CLK_RATIO = 32'h0000_0174;

  // ***************************************************************
  // Field positions and widths
  // ***************************************************************
  localparam int          CR_DTR_ASSERT  = 16;
  localparam int          CR_DTR_RELEASE = 17;
  localparam int          CR_RTS_ASSERT  = 18;
  localparam int          CR_RTS_RELEASE = 19;
  localparam int          MR_LINE_LSB    = 0;
  localparam int          MR_CHANNEL_MODE_FIELD_LSB  = 14;
  localparam int          SR_TX_DONE     = 9;
  localparam int          SR_CHANGE_LSB  = 16;
  localparam int          SR_LEVEL_LSB   = 20;
  localparam int          BAUD_CD_W      = 16;
  localparam int          FILT_W         = 8;
  localparam int          TG_W           = 8;
  localparam int          RATIO_W        = 11;

  // ***************************************************************
  // Mode encodings
  // ***************************************************************
  localparam logic [3:0]  LINE_BUS      = 4'h1;
  localparam logic [3:0]  LINE_MODEM    = 4'h3;
  localparam logic [3:0]  LINE_IR       = 4'h8;
  localparam logic [1:0]  CH_NORMAL     = 2'h0;
  localparam logic [1:0]  CH_ECHO       = 2'h1;
  localparam logic [1:0]  CH_LOCAL      = 2'h2;
  localparam logic [1:0]  CH_REMOTE     = 2'h3;

  // ***************************************************************
  // Timing, bus response code and filter states
  // ***************************************************************
  localparam int          OVERSAMPLE    = 16;
  localparam int          PULSE_SIXTEENTHS = 3;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;

  typedef enum logic [1:0] {
    ULML_FILT_IDLE,
    ULML_FILT_COUNT,
    ULML_FILT_FORCE
  } ulml_filt_t;

endpackage : ulml_pkg

/* File: verilog/ulml_line_mode.sv */
`timescale 1ns/10ps
module ulml_line_mode
  import ulml_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              rxd_pin,
  output logic                   txd_pin,
  output logic                   rts_pin,
  output logic                   dtr_pin,
  input  wire logic              ri_pin,
  input  wire logic              dsr_pin,
  input  wire logic              dcd_pin,
  input  wire logic              cts_pin,
  input  wire logic              core_txd,
  input  wire logic              core_tx_empty,
  output logic                   core_rxd,
  output logic                   core_tx_allow,
  output logic                   core_rx_allow
);

  // ***************************************************************
  // Registers and wires
  // ***************************************************************
  logic [31:0]         mode_reg;
  logic [31:0]         imr_reg;
  logic [BAUD_CD_W-1:0] cd_reg;
  logic [31:0]         rx_tmo_reg;
  logic [TG_W-1:0]     tg_reg;
  logic [RATIO_W-1:0]  ratio_reg;
  logic [FILT_W-1:0]   filt_reg;
  logic [3:0]          chg_reg;
  logic [ADDR_W-1:0]   awaddr_reg;
  logic [31:0]         wdata_reg;
  logic [3:0]          wstrb_reg;
  logic                aw_full_reg;
  logic                w_full_reg;
  logic                wr_en;
  logic                rd_en;
  logic                sr_rd;
  logic [3:0]          line_mode;
  logic [1:0]          ch_mode;
  logic [19:0]         bit_cycles;
  logic [17:0]         pulse_cycles;
  logic                rx_s1_reg;
  logic                rx_s2_reg;
  logic                rx_s3_reg;
  logic [3:0]          mdm_s1_reg;
  logic [3:0]          mdm_s2_reg;
  logic [3:0]          mdm_s3_reg;
  ulml_filt_t          filt_state_reg;
  logic [FILT_W-1:0]   filt_cnt_reg;
  logic [19:0]         force_cnt_reg;
  logic                demod_rx;
  logic                prev_txd_reg;
  logic [19:0]         mod_cnt_reg;
  logic                mod_out;
  logic                tx_empty_d_reg;
  logic [TG_W-1:0]     tg_left_reg;
  logic [19:0]         tg_cnt_reg;
  logic                tx_busy;
  logic                rts_cmd_reg;
  logic                cts_block;

  assign line_mode    = mode_reg[MR_LINE_LSB +: 4];
  assign ch_mode      = mode_reg[MR_CHANNEL_MODE_FIELD_LSB +: 2];
  assign bit_cycles   = {cd_reg, 4'h0};
  assign pulse_cycles = 18'(cd_reg) * 18'(PULSE_SIXTEENTHS);
  assign wr_en        = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign rd_en        = s_axi_arvalid && s_axi_arready;
  assign sr_rd        = rd_en && (s_axi_araddr == OFS_STATUS);

  function automatic logic [31:0] merge_strb(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  function automatic logic is_write(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs,
                                    input logic              en);
    return en && (a == ofs);
  endfunction : is_write

  // ***************************************************************
  // AXI4-Lite write channel
  // ***************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= RST_ZERO;
      wstrb_reg   <= 4'h0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Ready is registered; it drops the cycle after a take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_full_reg && !(s_axi_awvalid && s_axi_awready) && !wr_en;
      s_axi_wready  <= !w_full_reg && !(s_axi_wvalid && s_axi_wready) && !wr_en;
    end
  end

  // ***************************************************************
  // Configuration registers
  // ***************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg   <= RST_ZERO;
      imr_reg    <= RST_ZERO;
      cd_reg     <= '0;
      rx_tmo_reg <= RST_ZERO;
      tg_reg     <= '0;
      ratio_reg  <= RST_CLK_RATIO[RATIO_W-1:0];
      filt_reg   <= '0;
    end else if (wr_en) begin
      // Unlisted offsets fall through with no effect
      case (awaddr_reg)
        OFS_MODE:      mode_reg   <= merge_strb(mode_reg, wdata_reg, wstrb_reg);
        OFS_IRQ_EN:    imr_reg    <= imr_reg | wdata_reg;
        OFS_IRQ_DIS:   imr_reg    <= imr_reg & ~wdata_reg;
        OFS_BAUD:      cd_reg     <= BAUD_CD_W'(merge_strb(32'(cd_reg), wdata_reg,
                                                           wstrb_reg));
        OFS_RX_TMO:    rx_tmo_reg <= merge_strb(rx_tmo_reg, wdata_reg, wstrb_reg);
        OFS_TIMEGUARD: tg_reg     <= TG_W'(merge_strb(32'(tg_reg), wdata_reg,
                                                      wstrb_reg));
        OFS_CLK_RATIO: ratio_reg  <= RATIO_W'(merge_strb(32'(ratio_reg), wdata_reg,
                                                         wstrb_reg));
        OFS_IR_FILTER: filt_reg   <= FILT_W'(merge_strb(32'(filt_reg), wdata_reg,
                                                        wstrb_reg));
        default: ;
      endcase
    end
  end

  // ***************************************************************
  // AXI4-Lite read channel
  // ***************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= RST_ZERO;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (rd_en) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        case (s_axi_araddr)
          OFS_MODE:      s_axi_rdata <= mode_reg;
          OFS_IRQ_MASK:  s_axi_rdata <= imr_reg;
          OFS_STATUS:    s_axi_rdata <= (32'(mdm_s2_reg) << SR_LEVEL_LSB)
                                      | (32'(chg_reg) << SR_CHANGE_LSB)
                                      | (32'(core_tx_empty) << SR_TX_DONE);
          OFS_BAUD:      s_axi_rdata <= 32'(cd_reg);
          OFS_RX_TMO:    s_axi_rdata <= rx_tmo_reg;
          OFS_TIMEGUARD: s_axi_rdata <= 32'(tg_reg);
          OFS_CLK_RATIO: s_axi_rdata <= 32'(ratio_reg);
          OFS_IR_FILTER: s_axi_rdata <= 32'(filt_reg);
          default:       s_axi_rdata <= RST_ZERO;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_s1_reg  <= 1'b1;
      rx_s2_reg  <= 1'b1;
      rx_s3_reg  <= 1'b1;
      mdm_s1_reg <= 4'hF;
      mdm_s2_reg <= 4'hF;
      mdm_s3_reg <= 4'hF;
    end else begin
      rx_s1_reg  <= rxd_pin;
      rx_s2_reg  <= rx_s1_reg;
      rx_s3_reg  <= rx_s2_reg;
      mdm_s1_reg <= {cts_pin, dcd_pin, dsr_pin, ri_pin};
      mdm_s2_reg <= mdm_s1_reg;
      mdm_s3_reg <= mdm_s2_reg;
    end
  end

  // ***************************************************************
  // Modem change flags
  // ***************************************************************
  // A change landing on the clearing read is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chg_reg <= 4'h0;
    end else begin
      chg_reg <= (chg_reg & {4{!sr_rd}}) | (mdm_s2_reg ^ mdm_s3_reg);
    end
  end

  // ***************************************************************
  // Infrared receive filter
  // ***************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_state_reg <= ULML_FILT_IDLE;
      filt_cnt_reg   <= '0;
      force_cnt_reg  <= '0;
    end else begin
      case (filt_state_reg)
        ULML_FILT_IDLE: begin
          filt_cnt_reg <= filt_reg;
          if (line_mode == LINE_IR && rx_s3_reg && !rx_s2_reg) begin
            filt_state_reg <= ULML_FILT_COUNT;
          end
        end
        ULML_FILT_COUNT: begin
          if (rx_s2_reg && !rx_s3_reg) begin
            filt_cnt_reg   <= filt_reg;
            filt_state_reg <= ULML_FILT_IDLE;
          end else if (filt_cnt_reg == '0) begin
            force_cnt_reg  <= bit_cycles;
            filt_state_reg <= ULML_FILT_FORCE;
          end else begin
            filt_cnt_reg <= filt_cnt_reg - 1'b1;
          end
        end
        ULML_FILT_FORCE: begin
          if (force_cnt_reg <= 20'h00001) begin
            filt_cnt_reg   <= filt_reg;
            filt_state_reg <= ULML_FILT_IDLE;
          end else begin
            force_cnt_reg <= force_cnt_reg - 1'b1;
          end
        end
        default: filt_state_reg <= ULML_FILT_IDLE;
      endcase
    end
  end

  assign demod_rx = (filt_state_reg != ULML_FILT_FORCE);

  // ***************************************************************
  // Infrared modulator
  // ***************************************************************
  // Bit timer restarts on each transmitter edge so pulses stay aligned
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_txd_reg <= 1'b1;
      mod_cnt_reg  <= '0;
    end else begin
      prev_txd_reg <= core_txd;
      if (core_txd != prev_txd_reg || mod_cnt_reg + 20'h00001 >= bit_cycles) begin
        mod_cnt_reg <= '0;
      end else begin
        mod_cnt_reg <= mod_cnt_reg + 1'b1;
      end
    end
  end

  // LED on is high; ones and idle keep it dark
  assign mod_out = !core_txd && (core_txd == prev_txd_reg) &&
                   (mod_cnt_reg < 20'(pulse_cycles));

  // ***************************************************************
  // Timeguard hold for line driver
  // ***************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_empty_d_reg <= 1'b1;
      tg_left_reg    <= '0;
      tg_cnt_reg     <= '0;
    end else begin
      tx_empty_d_reg <= core_tx_empty;
      if (!core_tx_empty) begin
        tg_left_reg <= '0;
        tg_cnt_reg  <= '0;
      end else if (!tx_empty_d_reg) begin
        tg_left_reg <= tg_reg;
        tg_cnt_reg  <= '0;
      end else if (tg_left_reg != '0) begin
        if (tg_cnt_reg + 20'h00001 >= bit_cycles) begin
          tg_cnt_reg  <= '0;
          tg_left_reg <= tg_left_reg - 1'b1;
        end else begin
          tg_cnt_reg <= tg_cnt_reg + 1'b1;
        end
      end
    end
  end

  // Covers the edge where the hold is loaded, so no gap opens before it
  assign tx_busy   = !core_tx_empty || (tg_left_reg != '0) ||
                     (!tx_empty_d_reg && tg_reg != '0);
  assign cts_block = (line_mode == LINE_MODEM) && mdm_s2_reg[3];

  // ***************************************************************
  // Modem command latches
  // ***************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dtr_pin     <= 1'b1;
      rts_cmd_reg <= 1'b1;
    end else if (is_write(awaddr_reg, OFS_CONTROL, wr_en)) begin
      if (wdata_reg[CR_DTR_RELEASE]) begin
        dtr_pin <= 1'b1;
      end else if (wdata_reg[CR_DTR_ASSERT]) begin
        dtr_pin <= 1'b0;
      end
      if (wdata_reg[CR_RTS_RELEASE]) begin
        rts_cmd_reg <= 1'b1;
      end else if (wdata_reg[CR_RTS_ASSERT]) begin
        rts_cmd_reg <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Line and channel routing
  // ***************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_pin       <= 1'b1;
      rts_pin       <= 1'b1;
      core_rxd      <= 1'b1;
      core_tx_allow <= 1'b0;
      core_rx_allow <= 1'b0;
    end else begin
      case (line_mode)
        LINE_BUS:   rts_pin <= tx_busy;
        LINE_MODEM: rts_pin <= !tx_busy;
        default:    rts_pin <= rts_cmd_reg;
      endcase
      // Core finishes a running character; only new starts wait
      core_tx_allow <= (ch_mode != CH_REMOTE) && !cts_block;
      core_rx_allow <= (ch_mode != CH_REMOTE);
      case (ch_mode)
        CH_NORMAL: begin
          txd_pin  <= (line_mode == LINE_IR) ? mod_out : core_txd;
          core_rxd <= (line_mode == LINE_IR) ? demod_rx : rx_s2_reg;
        end
        CH_ECHO: begin
          txd_pin  <= rx_s2_reg;
          core_rxd <= (line_mode == LINE_IR) ? demod_rx : rx_s2_reg;
        end
        CH_LOCAL: begin
          txd_pin  <= 1'b1;
          core_rxd <= core_txd;
        end
        CH_REMOTE: begin
          txd_pin  <= rx_s2_reg;
          core_rxd <= 1'b1;
        end
        default: begin
          txd_pin  <= 1'b1;
          core_rxd <= 1'b1;
        end
      endcase
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  chk_filter_reload: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (filt_state_reg == ULML_FILT_COUNT && rx_s2_reg && !rx_s3_reg)
      |=> (filt_state_reg == ULML_FILT_IDLE && filt_cnt_reg == $past(filt_reg)))
    else $error("filter did not reload on rising edge");

  chk_filter_step: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (filt_state_reg == ULML_FILT_COUNT && !(rx_s2_reg && !rx_s3_reg)
      && filt_cnt_reg != '0) |=> (filt_cnt_reg == $past(filt_cnt_reg) - 8'h01))
    else $error("filter counter did not step down by one");

  chk_force_low: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (filt_state_reg == ULML_FILT_COUNT && filt_cnt_reg == '0 && !(rx_s2_reg && !rx_s3_reg)
      && line_mode == LINE_IR && ch_mode == CH_NORMAL && cd_reg != '0)
      |=> ##1 !core_rxd)
    else $error("receiver input not forced low after filter expiry");

  chk_bus_rts: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (line_mode == LINE_BUS && !core_tx_empty) |=> rts_pin)
    else $error("bus mode request-to-send low while transmitting");

  chk_tg_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (line_mode == LINE_BUS && $rose(core_tx_empty) && tg_reg != '0) |=> rts_pin)
    else $error("request-to-send dropped at start of timeguard");

  chk_dtr_cmd: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && awaddr_reg == OFS_CONTROL && wdata_reg[CR_DTR_ASSERT]
      && !wdata_reg[CR_DTR_RELEASE]) |=> !dtr_pin)
    else $error("terminal-ready not driven low by assert command");

  chk_flag_set: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (mdm_s2_reg[0] != mdm_s3_reg[0]) |=> chg_reg[0])
    else $error("ring change flag not set");

  chk_flag_clear: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (sr_rd && mdm_s2_reg == mdm_s3_reg) |=> (chg_reg == 4'h0))
    else $error("status read did not clear change flags");

  chk_cts_block: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (line_mode == LINE_MODEM && mdm_s2_reg[3]) |=> !core_tx_allow)
    else $error("transmitter allowed while clear-to-send inactive");

  chk_local_idle: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ch_mode == CH_LOCAL) |=> (txd_pin && core_rxd == $past(core_txd)))
    else $error("local loopback routing wrong");

  chk_remote_route: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ch_mode == CH_REMOTE) |=> (txd_pin == $past(rx_s2_reg) && !core_rx_allow))
    else $error("remote loopback routing wrong");

endmodule : ulml_line_mode

/* File: verification/ulml_line_partner.sv */
`timescale 1ns/10ps
module ulml_line_partner (
  input  wire logic       aclk,
  input  wire logic       rxd_want,
  input  wire logic [3:0] lvl_want,
  output logic            rxd_pin,
  output logic            ri_pin,
  output logic            dsr_pin,
  output logic            dcd_pin,
  output logic            cts_pin
);
  // Far end changes its lines just after the edge, like a real modem
  always_ff @(posedge aclk) begin
    rxd_pin <= rxd_want;
    {cts_pin, dcd_pin, dsr_pin, ri_pin} <= lvl_want;
  end
endmodule : ulml_line_partner

/* File: verification/test_ulml_line_mode.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module test_ulml_line_mode;
  import ulml_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bq = 0, arv = 0, rq = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic awr, wr_, br_v, arr, rv, rxd, txd, rts, dtr, ri, dsr, dcd, cts, crxd, tok, rxok;
  logic [31:0] rdata;
  logic [1:0] br, rr, ws, rs;
  logic rxd_w = 1, ctxd = 1, cemp = 1;
  logic [3:0] lvl = 0;
  int mismatches = 0, n_compared = 0, zr, zt;
  logic [5:0] rows [4] = '{6'b00_0_1_1_0, 6'b01_0_1_0_0, 6'b10_1_0_1_0, 6'b11_0_1_0_0};
  ulml_line_mode ulml_line_mode_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(br_v),
    .s_axi_bready(bq), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rq),
    .rxd_pin(rxd), .txd_pin(txd), .rts_pin(rts), .dtr_pin(dtr), .ri_pin(ri), .dsr_pin(dsr),
    .dcd_pin(dcd), .cts_pin(cts), .core_txd(ctxd), .core_tx_empty(cemp), .core_rxd(crxd),
    .core_tx_allow(tok), .core_rx_allow(rxok));
  ulml_line_partner ulml_line_partner_inst (.aclk(aclk), .rxd_want(rxd_w), .lvl_want(lvl),
    .rxd_pin(rxd), .ri_pin(ri), .dsr_pin(dsr), .dcd_pin(dcd), .cts_pin(cts));
  initial forever #5 aclk = ~aclk;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad = 0, dd = 0;
    @(posedge aclk); awa <= a; wd <= d; awv <= 1; wv <= 1; bq <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && awr) begin ad = 1; awv <= 0; end
      if (!dd && wr_) begin dd = 1; wv <= 0; end
    end
    do @(posedge aclk); while (br_v !== 1'b1);
    ws = br;
    bq <= 0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk); ara <= a; arv <= 1; rq <= 1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge aclk); while (rv !== 1'b1);
    rd = rdata;
    rs = rr;
    rq <= 0;
  endtask : rdr
  task automatic cyc(input int n); repeat (n) @(posedge aclk); endtask : cyc
  // Low pulse of n cycles on both receive pin and core transmit data
  task automatic pulse(input int n);
    zr = 0; zt = 0; rxd_w <= 0; ctxd <= 0;
    for (int i = 0; i < 48; i++) begin
      @(posedge aclk); if (i == n - 1) begin rxd_w <= 1; ctxd <= 1; end
      zr += (crxd === 1'b0); zt += (txd === 1'b1);
    end
  endtask : pulse
  task automatic stop_test;
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  initial begin #400000; mismatches++; stop_test; end
  initial begin
    cyc(3); aresetn <= 1; cyc(2);
    rdr(OFS_CLK_RATIO); `CHK(rd, RST_CLK_RATIO)
    rdr(8'h30); `CHK(rd, RST_ZERO)
    `CHK(rs, RESP_OKAY)
    wr(8'h2C, 32'hFFFF_FFFF);
    `CHK(ws, RESP_OKAY)
    rdr(OFS_MODE);
    `CHK(rd, RST_ZERO)
    foreach (rows[i]) begin
      wr(OFS_MODE, {16'h0, rows[i][5:4], 14'h0}); rxd_w <= rows[i][3]; ctxd <= rows[i][2]; cyc(6);
      `CHK(txd, rows[i][1])
      if (i < 3) `CHK(crxd, rows[i][0])
      `CHK(rxok, i != 3)
    end
    rxd_w <= 1; ctxd <= 1;
    wr(OFS_CONTROL, 32'h0001_0000); cyc(2); `CHK(dtr, 1'b0)
    wr(OFS_CONTROL, 32'h0002_0000); cyc(2); `CHK(dtr, 1'b1)
    wr(OFS_BAUD, 32'h1); wr(OFS_MODE, {28'h0, LINE_BUS});
    cemp <= 0; cyc(3); `CHK(rts, 1'b1)
    cemp <= 1; cyc(3); `CHK(rts, 1'b0)
    wr(OFS_TIMEGUARD, 32'h1); cemp <= 0; cyc(3); cemp <= 1; cyc(10);
    `CHK(rts, 1'b1)
    cyc(12); `CHK(rts, 1'b0)
    wr(OFS_MODE, {28'h0, LINE_MODEM}); rdr(OFS_STATUS);
    cemp <= 0; lvl <= 4'h1; cyc(6); `CHK(rts, 1'b0)
    `CHK(tok, 1'b1)
    rdr(OFS_STATUS); `CHK(rd[SR_CHANGE_LSB], 1'b1)
    rdr(OFS_STATUS); `CHK(rd[SR_CHANGE_LSB], 1'b0)
    cemp <= 1; lvl <= 4'h9; cyc(6); `CHK(tok, 1'b0)
    lvl <= 0; wr(OFS_IR_FILTER, 32'h4); wr(OFS_MODE, {28'h0, LINE_IR}); cyc(40);
    pulse(2); `CHK(zr, 0)
    cyc(20); pulse(16); `CHK(zr, 16)
    `CHK(zt, PULSE_SIXTEENTHS)
    aresetn <= 0;
    cyc(3);
    `CHK({txd, rts, dtr, crxd, tok, rxok}, 6'b111100)
    aresetn <= 1;
    cyc(2);
    rdr(OFS_MODE);
    `CHK(rd, RST_ZERO)
    rdr(OFS_CLK_RATIO);
    `CHK(rd, RST_CLK_RATIO)
    stop_test;
  end
endmodule : test_ulml_line_mode
